// [shared_ram_interface_arbiter_tb.sv]
`timescale 1ns/1ns
module shared_ram_interface_arbiter_tb import sri_pkg::*; ;
	logic              aclk      = 1'b0;
	logic              aresetn   = 1'b0;
	logic [AXI_AW-1:0] awaddr    = '0;
	logic [AXI_AW-1:0] araddr    = '0;
	logic [31:0]       wdata     = '0;
	logic              awvalid   = 1'b0;
	logic              wvalid    = 1'b0;
	logic              bready    = 1'b0;
	logic              arvalid   = 1'b0;
	logic              rready    = 1'b0;
	logic [3:0]        req_valid = '0;
	sri_req_t [3:0]    req_cmd   = '0;
	logic              xtal      = 1'b0;
	logic              xtal_en   = 1'b0;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [1:0]        bresp, rresp;
	logic [31:0]       rdata;
	logic [3:0]        req_done;
	logic [15:0]       req_rdata, mem_dq_o, mem_dq_i;
	sri_mem_t          mem_o;
	logic              mem_oe_n, mem_dq_oe_n;
	int                n_mismatch  = 0;
	int                comparisons = 0;
	int                cyc         = 0;

	sri_arbiter uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awprot(3'h0), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .req_valid(req_valid),
		.req_cmd(req_cmd), .req_done(req_done), .req_rdata(req_rdata),
		.crystal_clock_in(xtal), .mem_o(mem_o), .mem_oe_n(mem_oe_n),
		.mem_dq_o(mem_dq_o), .mem_dq_oe_n(mem_dq_oe_n),
		.mem_dq_i(mem_dq_i));

	sri_mem_model mem (.aclk(aclk), .mem_o(mem_o), .mem_dq_o(mem_dq_o),
		.mem_dq_oe_n(mem_dq_oe_n), .mem_dq_i(mem_dq_i));

	always #10 aclk = ~aclk;

	always begin
		repeat (4) @(posedge aclk);
		if (xtal_en)
			xtal <= ~xtal;
	end

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			test_done();
		end
	end

	// ---------------------------------------------------------------
	// Bus tasks and expectations
	// ---------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task axw(input logic [11:0] a, input logic [31:0] d);
		logic ta, tw, ra, rw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!(ta && tw)) begin
			@(negedge aclk);
			ra = awready && !ta;
			rw = wready && !tw;
			@(posedge aclk);
			if (ra) begin
				awvalid <= 1'b0;
				ta = 1'b1;
			end
			if (rw) begin
				wvalid <= 1'b0;
				tw = 1'b1;
			end
		end
		do begin
			@(negedge aclk);
			ra = bvalid;
			rw = (bresp === RESP_OKAY);
			@(posedge aclk);
		end while (!ra);
		bready <= 1'b0;
		chk(rw, 1'b1);
	endtask

	task axr(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic s;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(negedge aclk);
			s = arready;
			@(posedge aclk);
		end while (!s);
		arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			s = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
		end while (!s);
		rready <= 1'b0;
	endtask

	task req_set(input int i, input logic wr, input logic [22:0] a,
		input logic [15:0] d);
		req_cmd[i]   <= '{wr, 1'b0, 1'b0, a, d};
		req_valid[i] <= 1'b1;
	endtask

	task wait_done(input int i, input int lat);
		logic early;
		early = 1'b0;
		for (int k = 1; k < lat; k++) begin
			@(posedge aclk);
			#1 early = early | req_done[i];
		end
		@(posedge aclk);
		req_valid[i] <= 1'b0;
		#1;
		chk(early, 1'b0);
		chk(req_done[i], 1'b1);
		chk(mem_oe_n, 1'b1);
	endtask

	function automatic int ph(input logic b);
		return b ? 3 : 2;
	endfunction

	function automatic int lat_of(input logic [15:0] c, input logic wr);
		int t[4] = '{2, 3, 5, 6};
		if (c[3:1] inside {3'b010, 3'b011, 3'b100})
			return ph(c[4]) + ph(c[5]) + ph(c[6]) + ph(c[7]) + 1;
		return (wr ? t[c[5:4]] : t[c[7:6]]) + 3;
	endfunction

	task test_done;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [15:0] cfg, dat;
		logic [22:0] a;
		int          t0, t1;
		d = $urandom(32'hA993);
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axr(12'h0C8, d, r);
		chk(d, 32'h0000E4F0);
		axr(12'h0F0, d, r);
		chk(r, RESP_SLVERR);
		for (int n = 0; n < 10; n++) begin
			cfg = {8'hE4, 4'($urandom), 3'(n % 5), 1'b0};
			axw(12'h0C8, {16'h0000, cfg});
			a   = 23'($urandom);
			dat = 16'($urandom);
			@(posedge aclk);
			req_set(1, 1'b1, a, dat);
			wait_done(1, lat_of(cfg, 1'b1));
			@(posedge aclk);
			req_set(n % 4, 1'b0, a, 16'h0000);
			wait_done(n % 4, lat_of(cfg, 1'b0));
			chk(req_rdata, dat);
		end
		for (int p = 0; p < 2; p++) begin
			cfg = {p ? 8'h1B : 8'hE4, 8'h04};
			axw(12'h0C8, {16'h0000, cfg});
			@(posedge aclk);
			req_set(0, 1'b1, 23'h000010, 16'h1234);
			req_set(3, 1'b1, 23'h000011, 16'h5678);
			wait_done(p ? 3 : 0, lat_of(cfg, 1'b1));
			wait_done(p ? 0 : 3, lat_of(cfg, 1'b1));
		end
		axw(12'h100, 32'h00000001);
		repeat (2) @(negedge aclk);
		chk(mem_oe_n, 1'b0);
		axr(12'h100, d, r);
		chk(d, 32'h00000001);
		axw(12'h100, 32'h00000000);
		repeat (2) @(negedge aclk);
		chk(mem_oe_n, 1'b1);
		xtal_en <= 1'b1;
		t0 = 0;
		repeat (4400) begin
			@(negedge aclk);
			t0 += (mem_o.row_strobe_n === 1'b0);
		end
		chk(t0, 0);
		axw(12'h0C8, 32'h0000E405);
		repeat (2) begin
			while (mem_o.row_strobe_n !== 1'b1) @(negedge aclk);
			while (mem_o.row_strobe_n !== 1'b0) @(negedge aclk);
			t1 = t0;
			t0 = cyc;
		end
		chk((t0 - t1) inside {[4088:4104]}, 1'b1);
		// A requester that never lets go must not starve refresh
		@(posedge aclk);
		req_set(0, 1'b1, 23'h7FFF00, 16'hA5A5);
		while (mem_o.addr[22:11] === 12'h000) @(negedge aclk);
		while (mem_o.row_strobe_n !== 1'b0 ||
			mem_o.addr[22:11] !== 12'h000) @(negedge aclk);
		chk((cyc - t0) inside {[6100:6200]}, 1'b1);
		@(posedge aclk);
		req_valid[0] <= 1'b0;
		test_done();
	end
endmodule

// [sri_arbiter.sv]
// Notes on behaviour
// - Refresh runs only while configuration bit 0 set.
// - Refresh request every 512 crystal clock periods.
// - Three-bit code selects SRAM or DRAM organisation.
// - Refresh pace covers every supported DRAM size.
// - DRAM start to row strobe: 60/30ns.
// - Row strobe to column strobe: 60/30ns.
// - Column strobe low time: 60/30ns.
// - Column strobe rise to cycle end: 60/30ns.
// - DRAM cycle equals sum of four phases.
// - Outputs float during last 15ns of cycle.
// - SRAM write: edge, select low time, edge.
// - SRAM read: output enable time plus 30ns.
// - Between cycles, bus drive follows control bit.
// - Four priority fields rank the four requesters.
// - Refresh ranks last, first once half-interval idle.
// - Reset priority order follows configuration reset value.
// - 23-bit word address plus byte select bit.
`timescale 1ns/1ns
module sri_arbiter import sri_pkg::*; (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite slave
	input  wire logic [AXI_AW-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [AXI_AW-1:0] araddr,
	input  wire logic [2:0]        arprot,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Internal requesters
	input  wire logic [3:0]        req_valid,
	input  wire sri_req_t [3:0]    req_cmd,
	output logic [3:0]             req_done,
	output logic [15:0]            req_rdata,
	// Refresh time base
	input  wire logic              crystal_clock_in,
	// External memory
	output sri_mem_t               mem_o,
	output logic                   mem_oe_n,
	output logic [15:0]            mem_dq_o,
	output logic                   mem_dq_oe_n,
	input  wire logic [15:0]       mem_dq_i
);

	// ---------------------------------------------------------------
	// Register file over AXI4-Lite
	// ---------------------------------------------------------------
	logic [15:0]       cfg_r, cfg_nxt;
	logic              mbl_r, mbl_nxt;
	logic              aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
	logic [AXI_AW-1:0] awaddr_r, awaddr_nxt;
	logic [31:0]       wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic [3:0]        wstrb_r, wstrb_nxt;
	logic              bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [15:0]       status;

	assign awready = !aw_hold_r;
	assign wready  = !w_hold_r;
	assign arready = !rvalid_r;

	always_comb begin
		cfg_nxt     = cfg_r;
		mbl_nxt     = mbl_r;
		aw_hold_nxt = aw_hold_r;
		w_hold_nxt  = w_hold_r;
		awaddr_nxt  = awaddr_r;
		wdata_nxt   = wdata_r;
		wstrb_nxt   = wstrb_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		rvalid_nxt  = rvalid_r;
		rresp_nxt   = rresp_r;
		rdata_nxt   = rdata_r;
		if (awvalid && awready) begin
			aw_hold_nxt = 1'b1;
			awaddr_nxt  = awaddr;
		end
		if (wvalid && wready) begin
			w_hold_nxt = 1'b1;
			wdata_nxt  = wdata;
			wstrb_nxt  = wstrb;
		end
		if (bvalid_r && bready) begin
			bvalid_nxt = 1'b0;
		end
		// Write executes once address and data are both held
		if (aw_hold_r && w_hold_r && !bvalid_r) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = RESP_OKAY;
			case (awaddr_r[11:2])
				CFG_IDX: begin
					if (wstrb_r[0]) begin
						cfg_nxt[7:0] = wdata_r[7:0];
					end
					if (wstrb_r[1]) begin
						cfg_nxt[15:8] = wdata_r[15:8];
					end
				end
				CTRL_IDX: begin
					if (wstrb_r[0]) begin
						mbl_nxt = wdata_r[CTRL_MBL_BIT];
					end
				end
				STAT_IDX: begin
				end
				default: begin
					bresp_nxt = RESP_SLVERR;
				end
			endcase
		end
		if (rvalid_r && rready) begin
			rvalid_nxt = 1'b0;
		end
		if (arvalid && arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = RESP_OKAY;
			case (araddr[11:2])
				CFG_IDX:  rdata_nxt = {16'h0000, cfg_r};
				CTRL_IDX: rdata_nxt = {31'h00000000, mbl_r};
				STAT_IDX: rdata_nxt = {16'h0000, status};
				default: begin
					rdata_nxt = 32'h00000000;
					rresp_nxt = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_r     <= CFG_RST;
			mbl_r     <= 1'b0;
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			awaddr_r  <= '0;
			wdata_r   <= 32'h00000000;
			wstrb_r   <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
			rvalid_r  <= 1'b0;
			rresp_r   <= RESP_OKAY;
			rdata_r   <= 32'h00000000;
		end else begin
			cfg_r     <= cfg_nxt;
			mbl_r     <= mbl_nxt;
			aw_hold_r <= aw_hold_nxt;
			w_hold_r  <= w_hold_nxt;
			awaddr_r  <= awaddr_nxt;
			wdata_r   <= wdata_nxt;
			wstrb_r   <= wstrb_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			rvalid_r  <= rvalid_nxt;
			rresp_r   <= rresp_nxt;
			rdata_r   <= rdata_nxt;
		end
	end

	assign bvalid = bvalid_r;
	assign bresp  = bresp_r;
	assign rvalid = rvalid_r;
	assign rresp  = rresp_r;
	assign rdata  = rdata_r;

	// ---------------------------------------------------------------
	// Configuration decode
	// ---------------------------------------------------------------
	sri_org_t org;
	logic     cfg_dram;

	assign org      = sri_org_t'(cfg_r[CFG_ORG_LSB +: 3]);
	// codes 010, 011 and 100 are DRAM; others treated as SRAM
	assign cfg_dram = (org == ORG_DRAM_256K) || (org == ORG_DRAM_1M) ||
		(org == ORG_DRAM_4M);

	// ---------------------------------------------------------------
	// Refresh scheduling
	// ---------------------------------------------------------------
	logic        xtal_lvl, xtal_d_r, xtal_rise, ref_tick, ref_ok;
	logic [8:0]  xcnt_r, xcnt_nxt, urg_cnt_r, urg_cnt_nxt;
	logic        pend_r, pend_nxt, urgent;
	logic [10:0] ref_row_r, ref_row_nxt;
	logic        start, start_ref;

	sri_sync3 #(.W(1)) u_xtal_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (crystal_clock_in),
		.q       (xtal_lvl)
	);

	assign xtal_rise = xtal_lvl && !xtal_d_r;
	assign ref_tick  = xtal_rise && (xcnt_r == XTAL_LAST);
	assign ref_ok    = cfg_r[CFG_REF_BIT] && cfg_dram;
	assign urgent    = pend_r && (urg_cnt_r >= XTAL_URGENT);

	always_comb begin
		xcnt_nxt    = xtal_rise ? xcnt_r + 9'h001 : xcnt_r;
		// New request wins over the clear by a starting refresh
		pend_nxt    = ref_ok && (ref_tick || (pend_r && !start_ref));
		ref_row_nxt = start_ref ? ref_row_r + 11'h001 : ref_row_r;
		urg_cnt_nxt = urg_cnt_r;
		// A new request or the refresh's own access restarts the urgency count
		if (ref_tick || start_ref) begin
			urg_cnt_nxt = 9'h000;
		end else if (xtal_rise && (urg_cnt_r < XTAL_URGENT)) begin
			urg_cnt_nxt = urg_cnt_r + 9'h001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xtal_d_r  <= 1'b0;
			xcnt_r    <= 9'h000;
			pend_r    <= 1'b0;
			ref_row_r <= 11'h000;
			urg_cnt_r <= 9'h000;
		end else begin
			xtal_d_r  <= xtal_lvl;
			xcnt_r    <= xcnt_nxt;
			pend_r    <= pend_nxt;
			ref_row_r <= ref_row_nxt;
			urg_cnt_r <= urg_cnt_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Arbitration
	// ---------------------------------------------------------------
	logic       found;
	logic [1:0] pick;

	always_comb begin
		found = 1'b0;
		pick  = 2'b00;
		for (int k = 0; k < 4; k++) begin
			if (!found && req_valid[cfg_r[CFG_PRIO_LSB + 2 * k +: 2]]) begin
				found = 1'b1;
				pick  = cfg_r[CFG_PRIO_LSB + 2 * k +: 2];
			end
		end
	end

	// ---------------------------------------------------------------
	// Memory cycle sequencer
	// ---------------------------------------------------------------
	sri_state_t      state_r, state_nxt;
	logic [3:0]      cnt_r, cnt_nxt;
	logic [3:0][3:0] dur_r, dur_nxt, dur_calc;
	logic            is_dram_r, is_dram_nxt, is_wr_r, is_wr_nxt;
	logic            is_ref_r, is_ref_nxt;
	logic [1:0]      owner_r, owner_nxt;
	sri_req_t        cmd_r, cmd_nxt;
	logic [15:0]     rd_r, rd_nxt;
	logic [3:0]      done_r, done_nxt;
	logic            last_cyc;

	// a new grant only from idle, so a cycle is never cut short
	assign start     = (state_r == ST_IDLE) && (found || pend_r);
	assign start_ref = start && pend_r && (urgent || !found);
	assign last_cyc  = (state_r == ST_PH4) && (cnt_r <= CYC_HIZ);

	always_comb begin
		if (cfg_dram) begin
			dur_calc[0] = cfg_r[CFG_U_BIT] ? CYC_LONG : CYC_SHORT;
			dur_calc[1] = cfg_r[CFG_V_BIT] ? CYC_LONG : CYC_SHORT;
			dur_calc[2] = cfg_r[CFG_W_BIT] ? CYC_LONG : CYC_SHORT;
			dur_calc[3] = cfg_r[CFG_Z_BIT] ? CYC_LONG : CYC_SHORT;
		end else begin
			dur_calc[0] = CYC_SRAM_EDGE;
			dur_calc[2] = 4'h0;
			dur_calc[3] = CYC_SRAM_EDGE;
			if (found && req_cmd[pick].wr) begin
				dur_calc[1] = CYC_SRAM_STROBE[
					cfg_r[CFG_V_BIT:CFG_U_BIT]];
			end else begin
				dur_calc[1] = CYC_SRAM_STROBE[
					cfg_r[CFG_Z_BIT:CFG_W_BIT]];
			end
		end
	end

	always_comb begin
		state_nxt   = state_r;
		cnt_nxt     = cnt_r;
		dur_nxt     = dur_r;
		is_dram_nxt = is_dram_r;
		is_wr_nxt   = is_wr_r;
		is_ref_nxt  = is_ref_r;
		owner_nxt   = owner_r;
		cmd_nxt     = cmd_r;
		rd_nxt      = rd_r;
		done_nxt    = 4'h0;
		case (state_r)
			ST_IDLE: begin
				if (start) begin
					state_nxt   = ST_PH1;
					cnt_nxt     = dur_calc[0];
					dur_nxt     = dur_calc;
					is_dram_nxt = cfg_dram;
					is_ref_nxt  = start_ref;
					is_wr_nxt   = !start_ref && req_cmd[pick].wr;
					owner_nxt   = pick;
					cmd_nxt     = req_cmd[pick];
					if (start_ref) begin
						cmd_nxt      = '0;
						cmd_nxt.addr = {12'h000, ref_row_r};
					end
				end
			end
			ST_PH1: begin
				cnt_nxt = cnt_r - 4'h1;
				if (cnt_r == 4'h1) begin
					state_nxt = ST_PH2;
					cnt_nxt   = dur_r[1];
				end
			end
			ST_PH2: begin
				cnt_nxt = cnt_r - 4'h1;
				if (cnt_r == 4'h1) begin
					// SRAM has no column phase
					state_nxt = is_dram_r ? ST_PH3 : ST_PH4;
					cnt_nxt   = is_dram_r ? dur_r[2] : dur_r[3];
					if (!is_dram_r && !is_wr_r) begin
						rd_nxt = mem_dq_i;
					end
				end
			end
			ST_PH3: begin
				cnt_nxt = cnt_r - 4'h1;
				if (cnt_r == 4'h1) begin
					state_nxt = ST_PH4;
					cnt_nxt   = dur_r[3];
					if (!is_wr_r && !is_ref_r) begin
						rd_nxt = mem_dq_i;
					end
				end
			end
			ST_PH4: begin
				cnt_nxt = cnt_r - 4'h1;
				if (cnt_r == 4'h1) begin
					state_nxt = ST_IDLE;
					cnt_nxt   = 4'h0;
					if (!is_ref_r) begin
						done_nxt[owner_r] = 1'b1;
					end
				end
			end
			default: begin
				state_nxt = ST_IDLE;
				cnt_nxt   = 4'h0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r   <= ST_IDLE;
			cnt_r     <= 4'h0;
			dur_r     <= '0;
			is_dram_r <= 1'b0;
			is_wr_r   <= 1'b0;
			is_ref_r  <= 1'b0;
			owner_r   <= 2'b00;
			cmd_r     <= '0;
			rd_r      <= 16'h0000;
			done_r    <= 4'h0;
		end else begin
			state_r   <= state_nxt;
			cnt_r     <= cnt_nxt;
			dur_r     <= dur_nxt;
			is_dram_r <= is_dram_nxt;
			is_wr_r   <= is_wr_nxt;
			is_ref_r  <= is_ref_nxt;
			owner_r   <= owner_nxt;
			cmd_r     <= cmd_nxt;
			rd_r      <= rd_nxt;
			done_r    <= done_nxt;
		end
	end

	assign req_done  = done_r;
	assign req_rdata = rd_r;
	assign status    = {7'h00, state_r, urgent, pend_r, is_ref_r,
		owner_r, state_r != ST_IDLE};

	// ---------------------------------------------------------------
	// Memory pins except mem_dq_o, registered one cycle behind the sequencer
	// ---------------------------------------------------------------
	sri_mem_t mem_r, mem_nxt;
	logic     oe_n_r, oe_n_nxt, dq_oe_n_r, dq_oe_n_nxt;
	logic     busy, ph_data;

	assign busy    = state_r != ST_IDLE;
	assign ph_data = is_dram_r ? (state_r == ST_PH3) : (state_r == ST_PH2);

	always_comb begin
		mem_nxt              = mem_r;
		mem_nxt.addr         = cmd_r.addr;
		mem_nxt.byte_lsb     = cmd_r.byte_lsb;
		mem_nxt.byte_acc     = cmd_r.byte_acc;
		mem_nxt.row_strobe_n = !(is_dram_r && busy &&
			(state_r != ST_PH1));
		mem_nxt.col_strobe_n = !(is_dram_r && !is_ref_r &&
			(state_r == ST_PH3));
		mem_nxt.chip_sel_n   = !(!is_dram_r && (state_r == ST_PH2));
		mem_nxt.out_en_n     = !(busy && !is_wr_r && !is_ref_r &&
			ph_data);
		mem_nxt.wr_n         = !(busy && is_wr_r && ph_data);
		// Float in the last slice of a cycle, drive the rest of it, bus as configured when idle
		oe_n_nxt    = busy ? last_cyc : !mbl_r;
		dq_oe_n_nxt = !(busy && is_wr_r && !last_cyc);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mem_r     <= '{addr: 23'h000000, byte_lsb: 1'b0,
				byte_acc: 1'b0, default: 1'b1};
			oe_n_r    <= 1'b1;
			dq_oe_n_r <= 1'b1;
		end else begin
			mem_r     <= mem_nxt;
			oe_n_r    <= oe_n_nxt;
			dq_oe_n_r <= dq_oe_n_nxt;
		end
	end

	assign mem_o       = mem_r;
	assign mem_oe_n    = oe_n_r;
	assign mem_dq_oe_n = dq_oe_n_r;
	assign mem_dq_o    = cmd_r.wdata;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	logic [5:0] len_r;

	always_ff @(posedge aclk) begin
		if (!aresetn || !busy) begin
			len_r <= 6'h00;
		end else begin
			len_r <= len_r + 6'h01;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_dram_go;
		state_r == ST_IDLE ##1 state_r == ST_PH1 && is_dram_r;
	endsequence

	sequence s_cas_go;
		state_r == ST_PH2 ##1 state_r == ST_PH3;
	endsequence

	ref_gate_a: assert property (start_ref |-> cfg_r[CFG_REF_BIT])
		else $error("refresh started while refresh disabled");
	ref_tick_a: assert property ($rose(pend_r) |->
		$past(xtal_rise) && $past(xcnt_r) == XTAL_LAST)
		else $error("refresh request off the crystal count");
	row_long_a: assert property (s_dram_go ##0 $past(cfg_r[CFG_U_BIT])
		|-> (state_r == ST_PH1)[*3] ##1 state_r == ST_PH2)
		else $error("row strobe delay not 60ns");
	row_short_a: assert property (s_dram_go ##0 !$past(cfg_r[CFG_U_BIT])
		|-> (state_r == ST_PH1)[*2] ##1 state_r == ST_PH2)
		else $error("row strobe delay not 30ns");
	cas_low_a: assert property (s_cas_go ##0 dur_r[2] == CYC_LONG
		|-> (state_r == ST_PH3)[*3] ##1 state_r == ST_PH4)
		else $error("column strobe low time wrong");
	dram_len_a: assert property (last_cyc && is_dram_r && cnt_r == 4'h1
		|-> len_r + 6'h01 == 6'(dur_r[0] + dur_r[1] + dur_r[2] + dur_r[3]))
		else $error("dram cycle length not sum of phases");
	tail_float_a: assert property (last_cyc |=> mem_oe_n && mem_dq_oe_n)
		else $error("bus driven in last slice of cycle");
	sram_len_a: assert property (last_cyc && !is_dram_r && cnt_r == 4'h1
		|-> len_r + 6'h01 == 6'(dur_r[1] + 2 * CYC_SRAM_EDGE))
		else $error("sram cycle length wrong");
	idle_bus_a: assert property (!busy && !$past(busy)
		|=> mem_oe_n == !$past(mbl_r))
		else $error("idle bus drive not per control bit");
	top_rank_a: assert property (start && !start_ref
		&& req_valid[cfg_r[CFG_PRIO_LSB +: 2]]
		|=> owner_r == $past(cfg_r[CFG_PRIO_LSB +: 2]))
		else $error("first-ranked requester not granted");
	urgent_ref_a: assert property (start && urgent |=> is_ref_r)
		else $error("urgent refresh not granted first");
	no_preempt_a: assert property (busy && $past(busy)
		|-> owner_r == $past(owner_r) && is_ref_r == $past(is_ref_r))
		else $error("cycle owner changed mid cycle");
	reset_prio_a: assert property ($rose(aresetn) |-> cfg_r == CFG_RST)
		else $error("configuration not at reset value");

endmodule

// [sri_mem_model.sv]
`timescale 1ns/1ns
module sri_mem_model import sri_pkg::*; (
	// Clock
	input  wire logic        aclk,
	// Pins from the controller
	input  wire sri_mem_t    mem_o,
	input  wire logic [15:0] mem_dq_o,
	input  wire logic        mem_dq_oe_n,
	// Read data back to the controller
	output logic      [15:0] mem_dq_i
);
	logic [15:0] ram [256];
	logic [15:0] last_r = 16'h0000;
	wire         sel    = !mem_o.col_strobe_n || !mem_o.chip_sel_n;

	always @(posedge aclk) begin
		if (sel && !mem_o.wr_n && !mem_dq_oe_n)
			ram[mem_o.addr[7:0]] <= mem_dq_o;
		last_r <= mem_dq_i;
	end

	// Released lines toggle so a stale value never reads as good
	assign mem_dq_i = !mem_o.out_en_n ? ram[mem_o.addr[7:0]] : ~last_r;
endmodule

// [sri_pkg.sv]
package sri_pkg;

	// ---------------------------------------------------------------
	// Clock and strobe timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;

	function automatic logic [3:0] ns2cyc(input int ns);
		return 4'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	endfunction

	localparam int T_SHORT_NS     = 30;
	localparam int T_LONG_NS      = 60;
	localparam int T_SRAM_STEP_NS = 30;
	localparam int T_SRAM_EDGE_NS = 15;
	localparam int T_HIZ_NS       = 15;

	localparam logic [3:0] CYC_SHORT     = ns2cyc(T_SHORT_NS);
	localparam logic [3:0] CYC_LONG      = ns2cyc(T_LONG_NS);
	localparam logic [3:0] CYC_SRAM_EDGE = ns2cyc(T_SRAM_EDGE_NS);
	localparam logic [3:0][3:0] CYC_SRAM_STROBE = {
		ns2cyc(4 * T_SRAM_STEP_NS), ns2cyc(3 * T_SRAM_STEP_NS),
		ns2cyc(2 * T_SRAM_STEP_NS), ns2cyc(T_SRAM_STEP_NS)};
	// Longest time: round down, but never below one cycle
	localparam logic [3:0] CYC_HIZ = (T_HIZ_NS / CLK_PERIOD_NS) >= 1 ?
		4'(T_HIZ_NS / CLK_PERIOD_NS) : 4'h1;

	// ---------------------------------------------------------------
	// Refresh timing, counted on the crystal clock
	// ---------------------------------------------------------------
	localparam int REFRESH_PERIOD_US = 15625;
	localparam int XTAL_PER_REFRESH  = 512;
	localparam logic [8:0] XTAL_LAST   = 9'(XTAL_PER_REFRESH - 1);
	localparam logic [8:0] XTAL_URGENT = 9'(XTAL_PER_REFRESH / 2);

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam int          AXI_AW   = 12;
	localparam logic [9:0]  CFG_IDX  = 10'h032;
	localparam logic [9:0]  CTRL_IDX = 10'h040;
	localparam logic [9:0]  STAT_IDX = 10'h041;
	localparam logic [15:0] CFG_RST  = 16'hE4F0;
	localparam int CFG_REF_BIT  = 0;
	localparam int CFG_ORG_LSB  = 1;
	localparam int CFG_U_BIT    = 4;
	localparam int CFG_V_BIT    = 5;
	localparam int CFG_W_BIT    = 6;
	localparam int CFG_Z_BIT    = 7;
	localparam int CFG_PRIO_LSB = 8;
	localparam int CTRL_MBL_BIT = 0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ORG_SRAM_128K = 3'b000,
		ORG_SRAM_512K = 3'b001,
		ORG_DRAM_256K = 3'b010,
		ORG_DRAM_1M   = 3'b011,
		ORG_DRAM_4M   = 3'b100
	} sri_org_t;

	typedef enum logic [1:0] {
		RQ_RX_DMA = 2'b00,
		RQ_CPU    = 2'b01,
		RQ_TX_DMA = 2'b10,
		RQ_INTC   = 2'b11
	} sri_requester_code_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PH1  = 3'b001,
		ST_PH2  = 3'b010,
		ST_PH3  = 3'b011,
		ST_PH4  = 3'b100
	} sri_state_t;

	typedef struct packed {
		logic        wr;
		logic        byte_acc;
		logic        byte_lsb;
		logic [22:0] addr;
		logic [15:0] wdata;
	} sri_req_t;

	typedef struct packed {
		logic [22:0] addr;
		logic        byte_lsb;
		logic        byte_acc;
		logic        row_strobe_n;
		logic        col_strobe_n;
		logic        chip_sel_n;
		logic        out_en_n;
		logic        wr_n;
	} sri_mem_t;

endpackage

// [sri_sync3.sv]
`timescale 1ns/1ns
module sri_sync3 import sri_pkg::*; #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Asynchronous input and filtered level
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] s1_r, s2_r, s3_r, q_r;
	logic [W-1:0] q_nxt;

	// A bit changes only once the second and third stages agree
	always_comb begin
		for (int i = 0; i < W; i++) begin
			q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q_r  <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r  <= q_nxt;
		end
	end

	assign q = q_r;

endmodule
